// ### hdl/fcps_top.sv
// Pin select, tach output and locked-rotor timing of a single-phase fan
// driver, with an AXI4-Lite register slave.
// Assumes every pin input is synchronous to mclk and the tach pin has an
// external pull-up; the serial engine itself sits outside this block.
//
// Operation
// - A rotor that shows no Hall edge within the lock detect time after start-up trips lock protection and drive stops.
// - If the lock persists over restarts, the fifth and later off periods use a different, longer length.
// - In speed pulse mode the tach pin follows the Hall signal level.
// - The tach output select field at 0x010C picks speed pulse, rotation detect or rotation decline alarm.
// - The tach pin is only ever pulled low; the outside pull-up makes the high level.
// - Drive strength follows the measured duty ratio of the speed command input.
// - With the strap low the tach pin is the single two-way serial line.
// - With the strap high serial input comes from the speed command pin and replies go out on the tach pin.
// - While rotating, lock is declared once Hall edges have been absent for 0.3 s.
// - From the fifth off interval onward the off period is 15 times the restart on period.
`timescale 1ns/100ps
module fcps_top #(
   parameter int unsigned TICK_CYC      = fcps_pkg::TICK_CYC_DEF,
   parameter int unsigned DUTY_WIN_LOG2 = fcps_pkg::DUTY_WIN_LOG2_DEF
) (
   input  wire logic                    mclk,
   input  wire logic                    rst,
   input  wire fcps_pkg::fcps_axi_req_t axi_req,
   output      fcps_pkg::fcps_axi_rsp_t axi_rsp,
   input  wire logic                    hall_in_pos,
   input  wire logic                    hall_in_neg,
   input  wire logic                    pwm_in,
   input  wire logic                    comm_select_strap,
   input  wire logic                    tach_in,
   output      logic                    tach_out,
   output      logic                    tach_oe,
   input  wire logic                    ser_tx,
   input  wire logic                    ser_tx_en,
   input  wire logic                    ser_busy,
   output      logic                    ser_rx,
   output      logic                    drive_en,
   output      logic [7:0]              drive_duty,
   output      logic                    irq
);
   import fcps_pkg::*;

   localparam logic [TICK_W-1:0] TICK_LAST  = TICK_W'(TICK_CYC - 1);
   localparam logic [WIN_W-1:0]  WIN_LAST   =
      WIN_W'((1 << DUTY_WIN_LOG2) - 1);
   localparam int unsigned       DUTY_SHIFT = DUTY_WIN_LOG2 - DUTY_BITS;
   localparam logic [2:0]        LATE_PREV  = LATE_OFF_NUM - 3'h1;

   fcps_state_t          s_q;
   fcps_state_t          s_d;
   logic                 tick;
   logic                 hall_now;
   logic                 hall_edge;
   logic                 lock_hit;
   logic                 win_end;
   logic                 pin_serial;
   logic                 tach_func;
   logic                 aw_rdy;
   logic                 w_rdy;
   logic [1:0]           tsel;
   logic [1:0]           ld_sel;
   logic [7:0]           rda_thr;
   logic [15:0]          on_ms;
   logic [15:0]          off_ms;
   logic [IRQ_W-1:0]     ev;
   logic [IRQ_W-1:0]     w1c;
   logic [WIN_W-1:0]     duty_raw;

   ////////////////////////////////////////////////////////////////////////////
   // Helpers.
   function automatic logic [15:0] lock_ms(input logic [1:0] sel);
      case (sel)
         2'h0:    lock_ms = LD_MS_0;
         2'h1:    lock_ms = LD_MS_1;
         2'h2:    lock_ms = LD_MS_2;
         default: lock_ms = LD_MS_3;
      endcase
   endfunction
   function automatic logic [15:0] off_limit(input logic [15:0] on,
                                             input logic [2:0]  n);
      logic [31:0] prod;
      prod = (n >= LATE_OFF_NUM) ? on * OFF_RATIO_LATE
                                 : on * OFF_RATIO_EARLY;
      off_limit = prod[15:0];
   endfunction
   function automatic logic [31:0] merge_strb(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0]  strb);
      merge_strb = old_v;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            merge_strb[i*8 +: 8] = new_v[i*8 +: 8];
         end
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Next state.
   always_comb begin
      s_d      = s_q;
      ev       = '0;
      w1c      = '0;
      lock_hit = 1'b0;
      duty_raw = '0;
      tsel     = s_q.cfg[CFG_TSEL_LSB +: 2];
      ld_sel   = s_q.cfg[CFG_LD_LSB +: 2];
      rda_thr  = s_q.cfg[CFG_RDA_LSB +: 8];
      on_ms    = lock_ms(ld_sel);
      off_ms   = off_limit(on_ms, s_q.noff);
      aw_rdy   = !s_q.awgot && !s_q.bvalid;
      w_rdy    = !s_q.wgot && !s_q.bvalid;

      // Millisecond enable keeps all lock timers narrow.
      tick = (s_q.tick_cnt == TICK_LAST);
      s_d.tick_cnt = tick ? '0 : s_q.tick_cnt + 16'h0001;

      // The strap is caught once, on the first edge after reset release.
      if (!s_q.strap_done) begin
         s_d.strap      = comm_select_strap;
         s_d.strap_done = 1'b1;
      end

      // A tie between the Hall inputs keeps the last decided level.
      hall_now  = (hall_in_pos != hall_in_neg) ? hall_in_pos : s_q.hall;
      hall_edge = (hall_now != s_q.hall);
      s_d.hall  = hall_now;
      if (hall_edge) begin
         s_d.per_ms = '0;
      end else if (tick && s_q.per_ms != 16'hffff) begin
         s_d.per_ms = s_q.per_ms + 16'h0001;
      end

      if (tick && s_q.tmr != 16'hffff) begin
         s_d.tmr = s_q.tmr + 16'h0001;
      end
      case (s_q.st)
         ST_START, ST_RESTART: begin
            if (hall_edge) begin
               s_d.st   = ST_ROTATE;
               s_d.tmr  = '0;
               s_d.noff = '0;
               ev[IRQ_RESUME] = (s_q.st == ST_RESTART);
            end else if (s_q.tmr >= on_ms) begin
               lock_hit = 1'b1;
            end
         end
         ST_ROTATE: begin
            if (hall_edge) begin
               s_d.tmr = '0;
            end else if (s_q.tmr >= ROT_LOSS_MS) begin
               lock_hit = 1'b1;
            end
         end
         ST_OFF: begin
            if (s_q.tmr >= off_ms) begin
               s_d.st  = ST_RESTART;
               s_d.tmr = '0;
            end
         end
         default: begin
            s_d.st  = ST_START;
            s_d.tmr = '0;
         end
      endcase
      if (lock_hit) begin
         s_d.st  = ST_OFF;
         s_d.tmr = '0;
         if (s_q.noff != NOFF_MAX) begin
            s_d.noff = s_q.noff + 3'h1;
         end
         ev[IRQ_LOCK] = 1'b1;
         ev[IRQ_LATE] = (s_q.noff == LATE_PREV);
      end

      // The alarm also stands while not rotating at all.
      s_d.alarm = (s_q.st != ST_ROTATE) || (s_q.per_ms > {8'h00, rda_thr});
      ev[IRQ_ALARM] = s_d.alarm && !s_q.alarm;

      // duty measure
      // Fixed window of high samples; longer than the slowest command
      // period, so the reading is stable at the price of latency.
      win_end = (s_q.win_cnt == WIN_LAST);
      s_d.win_cnt = win_end ? '0 : s_q.win_cnt + 21'h000001;
      if (win_end) begin
         duty_raw   = s_q.hi_cnt >> DUTY_SHIFT;
         s_d.duty   = (|duty_raw[WIN_W-1:DUTY_BITS]) ? 8'hff
                                                      : duty_raw[7:0];
         s_d.hi_cnt = '0;
      end else if (pwm_in) begin
         s_d.hi_cnt = s_q.hi_cnt + 21'h000001;
      end
      s_d.drv_duty = (s_d.st == ST_OFF) ? 8'h00 : s_q.duty;

      case (tsel)
         TSEL_RD:  tach_func = (s_q.st == ST_ROTATE);
         TSEL_RDA: tach_func = s_q.alarm;
         default:  tach_func = !hall_now;
      endcase
      // serial pin routing
      // With the strap low the host talks on the tach pin, so the tach
      // function lets go of it for the whole session.
      pin_serial   = ser_tx_en || (!s_q.strap && ser_busy);
      s_d.tach_low = pin_serial ? (ser_tx_en && !ser_tx) : tach_func;
      s_d.ser_rx   = s_q.strap ? pwm_in : tach_in;

      // AXI4-Lite write path.
      if (axi_req.awvalid && aw_rdy) begin
         s_d.awgot  = 1'b1;
         s_d.awaddr = axi_req.awaddr;
      end
      if (axi_req.wvalid && w_rdy) begin
         s_d.wgot  = 1'b1;
         s_d.wdata = axi_req.wdata;
         s_d.wstrb = axi_req.wstrb;
      end
      if (s_q.bvalid && axi_req.bready) begin
         s_d.bvalid = 1'b0;
      end
      if (s_q.awgot && s_q.wgot && !s_q.bvalid) begin
         s_d.awgot  = 1'b0;
         s_d.wgot   = 1'b0;
         s_d.bvalid = 1'b1;
         s_d.bresp  = RESP_OKAY;
         case (s_q.awaddr)
            ADDR_CFG:   s_d.cfg = merge_strb(s_q.cfg, s_q.wdata, s_q.wstrb);
            ADDR_STAT:  w1c = s_q.wstrb[0] ? s_q.wdata[IRQ_W-1:0] : '0;
            ADDR_MASK: begin
               if (s_q.wstrb[0]) begin
                  s_d.mask = s_q.wdata[IRQ_W-1:0];
               end
            end
            ADDR_STATE: s_d.bresp = RESP_OKAY;
            default:    s_d.bresp = RESP_SLVERR;
         endcase
      end
      // A new event beats a clear in the same cycle.
      s_d.stat = (s_q.stat & ~w1c) | ev;

      // AXI4-Lite read path.
      if (s_q.rvalid && axi_req.rready) begin
         s_d.rvalid = 1'b0;
      end
      if (axi_req.arvalid && !s_q.rvalid) begin
         s_d.rvalid = 1'b1;
         s_d.rresp  = RESP_OKAY;
         case (axi_req.araddr)
            ADDR_CFG:   s_d.rdata = s_q.cfg;
            ADDR_STAT:  s_d.rdata = {28'h0, s_q.stat};
            ADDR_MASK:  s_d.rdata = {28'h0, s_q.mask};
            ADDR_STATE: s_d.rdata = {s_q.per_ms, s_q.noff, s_q.strap,
                                     s_q.st != ST_OFF, s_q.st, s_q.duty};
            default: begin
               s_d.rdata = '0;
               s_d.rresp = RESP_SLVERR;
            end
         endcase
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         s_q     <= '0;
         s_q.cfg <= CFG_RST;
      end else begin
         s_q <= s_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs.
   assign axi_rsp  = '{awready: aw_rdy, wready: w_rdy, bvalid: s_q.bvalid,
                       bresp: s_q.bresp, arready: !s_q.rvalid,
                       rvalid: s_q.rvalid, rdata: s_q.rdata,
                       rresp: s_q.rresp};
   assign tach_out   = 1'b0;
   assign tach_oe    = s_q.tach_low;
   assign ser_rx     = s_q.ser_rx;
   assign drive_en   = (s_q.st != ST_OFF);
   assign drive_duty = s_q.drv_duty;
   assign irq        = |(s_q.stat & s_q.mask);

   ////////////////////////////////////////////////////////////////////////////
   // Checks.
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);
   sequence s_start_timeout;
      s_q.st == ST_START && s_q.tmr >= on_ms && !hall_edge;
   endsequence
   sequence s_off_held;
      s_q.st == ST_OFF && !drive_en && drive_duty == 8'h00;
   endsequence
   property p_lock_engage;
      s_start_timeout |=> s_off_held ##1 (!drive_en);
   endproperty
   a_lock_engage: assert property (p_lock_engage)
      else $error("start-up lock did not stop drive");
   property p_fifth_off;
      (lock_hit && s_q.noff == LATE_PREV) |=>
         (s_q.noff == LATE_OFF_NUM && s_q.stat[IRQ_LATE] &&
          off_ms != off_limit(on_ms, 3'h1));
   endproperty
   a_fifth_off: assert property (p_fifth_off)
      else $error("fifth off period not switched to late length");
   property p_speed_pulse;
      (tsel == TSEL_SPEED && !pin_serial) |=> (tach_oe == !s_q.hall);
   endproperty
   a_speed_pulse: assert property (p_speed_pulse)
      else $error("tach pin does not follow hall level");
   property p_rd_select;
      (tsel == TSEL_RD && !pin_serial) |=>
         (tach_oe == $past(s_q.st == ST_ROTATE));
   endproperty
   a_rd_select: assert property (p_rd_select)
      else $error("rotation detect not on tach pin");
   property p_open_drain;
      (ser_tx_en && ser_tx) |=> (!tach_oe && tach_out == 1'b0);
   endproperty
   a_open_drain: assert property (p_open_drain)
      else $error("tach pin driven while it should float high");
   property p_duty_off;
      (s_q.st == ST_OFF)[*2] |-> (drive_duty == 8'h00 && !drive_en);
   endproperty
   a_duty_off: assert property (p_duty_off)
      else $error("drive duty not zero while stopped");
   property p_strap_low;
      (s_q.strap_done && !s_q.strap && ser_busy && !ser_tx_en) |=>
         (!tach_oe && ser_rx == $past(tach_in));
   endproperty
   a_strap_low: assert property (p_strap_low)
      else $error("tach pin not serial line with strap low");
   property p_strap_high;
      (s_q.strap_done && s_q.strap) |=> (ser_rx == $past(pwm_in));
   endproperty
   a_strap_high: assert property (p_strap_high)
      else $error("serial input not taken from command pin");
   property p_rot_loss;
      (s_q.st == ST_ROTATE && s_q.tmr >= ROT_LOSS_MS && !hall_edge) |=>
         (s_q.st == ST_OFF && s_q.stat[IRQ_LOCK]);
   endproperty
   a_rot_loss: assert property (p_rot_loss)
      else $error("rotation loss not declared as lock");
   property p_late_ratio;
      (s_q.st == ST_OFF && s_d.st == ST_RESTART &&
       s_q.noff >= LATE_OFF_NUM) |-> (s_q.tmr == off_limit(on_ms, 3'h5));
   endproperty
   a_late_ratio: assert property (p_late_ratio)
      else $error("late off period not fifteen on periods");
   sequence s_restart_edge;
      s_q.st == ST_RESTART && hall_edge;
   endsequence
   property p_restart;
      s_restart_edge |=> (s_q.st == ST_ROTATE && s_q.noff == 3'h0 &&
                          s_q.stat[IRQ_RESUME] && drive_en);
   endproperty
   a_restart: assert property (p_restart)
      else $error("restart did not resume rotation");
endmodule

// ### hdl/fcps_pkg.sv
// Constants, register map and carrier types for the fan pin select block.
// Assumes a single 20 MHz clock and a synchronous active-high reset.
package fcps_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Timing.
   localparam int unsigned CLK_HZ         = 20_000_000;
   localparam int unsigned TICK_MS        = 1;
   localparam int unsigned TICK_CYC_DEF   = CLK_HZ / 1000 * TICK_MS;
   localparam int unsigned TICK_W         = 16;
   localparam real         ROT_LOSS_S     = 0.3;
   localparam real         LD_S_0         = 0.2;
   localparam real         LD_S_1         = 0.4;
   localparam real         LD_S_2         = 0.6;
   localparam real         LD_S_3         = 0.95;
   localparam logic [15:0] ROT_LOSS_MS    = 16'(int'(ROT_LOSS_S * 1000.0));
   localparam logic [15:0] LD_MS_0        = 16'(int'(LD_S_0 * 1000.0));
   localparam logic [15:0] LD_MS_1        = 16'(int'(LD_S_1 * 1000.0));
   localparam logic [15:0] LD_MS_2        = 16'(int'(LD_S_2 * 1000.0));
   localparam logic [15:0] LD_MS_3        = 16'(int'(LD_S_3 * 1000.0));
   localparam logic [15:0] OFF_RATIO_EARLY = 16'h0009;
   localparam logic [15:0] OFF_RATIO_LATE  = 16'h000f;
   localparam logic [2:0]  LATE_OFF_NUM    = 3'h5;
   localparam logic [2:0]  NOFF_MAX        = 3'h7;

   ////////////////////////////////////////////////////////////////////////////
   // Duty measurement.
   localparam int unsigned DUTY_BITS         = 8;
   localparam int unsigned DUTY_WIN_LOG2_DEF = 20;
   localparam int unsigned WIN_W             = 21;

   ////////////////////////////////////////////////////////////////////////////
   // Register map.
   localparam int unsigned AW          = 12;
   localparam logic [AW-1:0] ADDR_CFG   = 12'h10c;
   localparam logic [AW-1:0] ADDR_STAT  = 12'h110;
   localparam logic [AW-1:0] ADDR_MASK  = 12'h114;
   localparam logic [AW-1:0] ADDR_STATE = 12'h118;
   localparam int unsigned CFG_TSEL_LSB = 0;
   localparam int unsigned CFG_LD_LSB   = 2;
   localparam int unsigned CFG_RDA_LSB  = 8;
   localparam logic [31:0] CFG_RST      = 32'h0000_200c;
   localparam logic [1:0]  TSEL_SPEED   = 2'h0;
   localparam logic [1:0]  TSEL_RD      = 2'h1;
   localparam logic [1:0]  TSEL_RDA     = 2'h2;
   localparam int unsigned IRQ_LOCK     = 0;
   localparam int unsigned IRQ_LATE     = 1;
   localparam int unsigned IRQ_RESUME   = 2;
   localparam int unsigned IRQ_ALARM    = 3;
   localparam int unsigned IRQ_W        = 4;
   localparam logic [1:0]  RESP_OKAY    = 2'h0;
   localparam logic [1:0]  RESP_SLVERR  = 2'h2;

   ////////////////////////////////////////////////////////////////////////////
   // Types.
   typedef enum logic [2:0] {ST_START, ST_ROTATE, ST_OFF, ST_RESTART}
      fcps_lock_st_t;

   typedef struct packed {
      logic [AW-1:0] awaddr;
      logic          awvalid;
      logic [31:0]   wdata;
      logic [3:0]    wstrb;
      logic          wvalid;
      logic          bready;
      logic [AW-1:0] araddr;
      logic          arvalid;
      logic          rready;
   } fcps_axi_req_t;

   typedef struct packed {
      logic        awready;
      logic        wready;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        arready;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
   } fcps_axi_rsp_t;

   typedef struct packed {
      logic                 awgot;
      logic                 wgot;
      logic [AW-1:0]        awaddr;
      logic [31:0]          wdata;
      logic [3:0]           wstrb;
      logic                 bvalid;
      logic [1:0]           bresp;
      logic                 rvalid;
      logic [31:0]          rdata;
      logic [1:0]           rresp;
      logic [31:0]          cfg;
      logic [IRQ_W-1:0]     stat;
      logic [IRQ_W-1:0]     mask;
      logic                 strap;
      logic                 strap_done;
      logic                 hall;
      logic [TICK_W-1:0]    tick_cnt;
      fcps_lock_st_t        st;
      logic [15:0]          tmr;
      logic [2:0]           noff;
      logic [15:0]          per_ms;
      logic                 alarm;
      logic [WIN_W-1:0]     win_cnt;
      logic [WIN_W-1:0]     hi_cnt;
      logic [DUTY_BITS-1:0] duty;
      logic [DUTY_BITS-1:0] drv_duty;
      logic                 tach_low;
      logic                 ser_rx;
   } fcps_state_t;

endpackage

// ### verification/fcps_host_model.sv
// Host side model: speed command or serial bit source, Hall source and
// the pulled-up tach wire. Assumes the bench drives its control inputs.
`timescale 1ns/100ps
module fcps_host_model (
   input  wire logic       mclk,
   input  wire logic       rst,
   input  wire logic [4:0] pwm_high,
   input  wire logic       ser_en,
   input  wire logic       ser_bit,
   input  wire logic       pull_low,
   input  wire logic       hall_lv,
   input  wire logic       tach_oe,
   input  wire logic       tach_out,
   output      logic       pwm_in,
   output      logic       tach_in,
   output      logic       hall_in_pos,
   output      logic       hall_in_neg
);
   logic [3:0] ph_q;
   always_ff @(posedge mclk) begin
      ph_q <= rst ? 4'h0 : ph_q + 4'h1;
   end
   assign pwm_in = ser_en ? ser_bit : ({1'h0, ph_q} < pwm_high);
   assign tach_in = !((tach_oe && !tach_out) || pull_low);
   assign hall_in_pos = hall_lv;
   assign hall_in_neg = !hall_lv;
endmodule

// ### verification/tb_comm_pin_select_tach_lock.sv
// Self-checking bench for the fan pin select block and its host model.
// Assumes fcps_pkg; one "ms" tick is TK cycles of the 20 MHz clock.
`timescale 1ns/100ps
module tb_comm_pin_select_tach_lock;
   import fcps_pkg::*;
   localparam int TK = 4;
   logic          mclk = 1'h0;
   logic          rst = 1'h1;
   fcps_axi_req_t req = '0;
   fcps_axi_rsp_t rsp;
   logic          strap = 1'h1;
   logic [4:0]    pwm_high = 5'h08;
   logic          ser_en = 1'h0;
   logic          ser_bit = 1'h0;
   logic          pull_low = 1'h0;
   logic          hall_lv = 1'h0;
   logic          ser_tx = 1'h0;
   logic          ser_tx_en = 1'h0;
   logic          ser_busy = 1'h0;
   logic          pwm_in, tach_in, hall_p, hall_n, tach_out, tach_oe;
   logic          ser_rx, drive_en, irq;
   logic [7:0]    drive_duty;
   logic [31:0]   seed = 32'h13be;
   logic [31:0]   q;
   logic [1:0]    r;
   int            bad_count = 0;
   int            checks_done = 0;
   int            n;
   always #25 mclk = !mclk;
   fcps_top #(.TICK_CYC(TK), .DUTY_WIN_LOG2(10)) dut (
      .mclk(mclk), .rst(rst), .axi_req(req), .axi_rsp(rsp),
      .hall_in_pos(hall_p), .hall_in_neg(hall_n), .pwm_in(pwm_in),
      .comm_select_strap(strap), .tach_in(tach_in), .tach_out(tach_out),
      .tach_oe(tach_oe), .ser_tx(ser_tx), .ser_tx_en(ser_tx_en),
      .ser_busy(ser_busy), .ser_rx(ser_rx), .drive_en(drive_en),
      .drive_duty(drive_duty), .irq(irq));
   fcps_host_model host (
      .mclk(mclk), .rst(rst), .pwm_high(pwm_high), .ser_en(ser_en),
      .ser_bit(ser_bit), .pull_low(pull_low), .hall_lv(hall_lv),
      .tach_oe(tach_oe), .tach_out(tach_out), .pwm_in(pwm_in),
      .tach_in(tach_in), .hall_in_pos(hall_p), .hall_in_neg(hall_n));
   ////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   function automatic logic [7:0] duty_exp(input logic [4:0] h);
      return (h * 16 > 255) ? 8'hff : 8'(h * 16);
   endfunction
   // Lock detect code 0 gives a 200 ms restart on period.
   function automatic int off_exp(input int k);
      return (k >= 5 ? 15 : 9) * 200 * TK;
   endfunction
   function automatic logic tach_exp(input logic [1:0] m, input logic h);
      case (m)
         TSEL_RD:  return 1'h1;
         TSEL_RDA: return 1'h0;
         default:  return !h;
      endcase
   endfunction
   task automatic end_of_test();
      if (bad_count == 0 && checks_done > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic check(input string nm, input logic [31:0] seen,
                        input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         $display("Error %s expected %h seen %h", nm, exp, seen);
         bad_count++;
      end
   endtask
   // Tick phase makes a timed interval land within a few ticks.
   task automatic near(input string nm, input int seen, input int exp);
      check(nm, (seen >= exp - 3 * TK && seen <= exp + 3 * TK) ? exp : seen,
            exp);
   endtask
   task automatic hang();
      bad_count++;
      end_of_test();
   endtask
   // Ready and valid are read at the falling edge, which is what the
   // next rising edge samples, so no race with the design's updates.
   task automatic bus(input logic wr, input logic [11:0] a,
                      input logic [31:0] d);
      logic ta, tw, dn;
      dn = 1'h0;
      @(posedge mclk);
      if (wr) begin
         req.awaddr <= a;
         req.awvalid <= 1'h1;
         req.wdata <= d;
         req.wstrb <= 4'hf;
         req.wvalid <= 1'h1;
         req.bready <= 1'h1;
      end else begin
         req.araddr <= a;
         req.arvalid <= 1'h1;
         req.rready <= 1'h1;
      end
      for (int i = 0; i < 50 && !dn; i++) begin
         @(negedge mclk);
         ta = wr ? req.awvalid && rsp.awready : req.arvalid && rsp.arready;
         tw = req.wvalid && rsp.wready;
         dn = wr ? req.bready && rsp.bvalid : req.rready && rsp.rvalid;
         q = rsp.rdata;
         r = wr ? rsp.bresp : rsp.rresp;
         @(posedge mclk);
         if (ta) begin
            req.awvalid <= 1'h0;
            req.arvalid <= 1'h0;
         end
         if (tw) req.wvalid <= 1'h0;
         if (dn) begin
            req.bready <= 1'h0;
            req.rready <= 1'h0;
         end
      end
      if (!dn) hang();
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      bus(1'h1, a, d);
      check("bresp", r, RESP_OKAY);
   endtask
   task automatic meas(input logic lv, input int lim);
      n = 0;
      while (drive_en === lv && n < lim) begin
         @(negedge mclk);
         n++;
      end
      if (n >= lim) hang();
   endtask
   // A Hall edge every 8 ms keeps the rotation alarm quiet.
   task automatic spin(input int cyc);
      repeat (cyc / 32) begin
         repeat (32) @(posedge mclk);
         hall_lv <= !hall_lv;
      end
   endtask
   initial begin
      repeat (4) @(posedge mclk);
      rst <= 1'h0;
      bus(1'h0, ADDR_CFG, 32'h0);
      check("cfg_rst", q, CFG_RST);
      bus(1'h0, ADDR_MASK, 32'h0);
      check("mask_rst", q, 32'h0);
      bus(1'h0, 12'h200, 32'h0);
      check("rdata_bad", q, 32'h0);
      check("rresp_bad", r, RESP_SLVERR);
      bus(1'h1, 12'h204, 32'h1);
      check("bresp_bad", r, RESP_SLVERR);
      wr(ADDR_CFG, 32'h2000);
      check("tach_out", tach_out, 1'h0);
      bus(1'h0, ADDR_STATE, 32'h0);
      check("strap_hi", q[12], 1'h1);
      for (int i = 0; i < 20; i++) begin
         q = xs();
         @(posedge mclk);
         hall_lv <= q[0];
         repeat (4 + q[4:1]) @(posedge mclk);
         @(negedge mclk);
         check("tach_spd", tach_oe, !hall_lv);
      end
      bus(1'h0, ADDR_STATE, 32'h0);
      check("rotate", q[10:8], 3'h1);
      for (int m = 0; m < 4; m++) begin
         wr(ADDR_CFG, 32'h2000 | m);
         hall_lv <= !hall_lv;
         repeat (6) @(posedge mclk);
         @(negedge mclk);
         check("tach_mode", tach_oe, tach_exp(m[1:0], hall_lv));
      end
      wr(ADDR_CFG, 32'h2000 | TSEL_RDA);
      repeat (200) @(posedge mclk);
      @(negedge mclk);
      check("alarm", tach_oe, 1'h1);
      for (int i = 0; i < 4; i++) begin
         q = xs();
         @(posedge mclk);
         pwm_high <= (i == 0) ? 5'h00 : (i == 1) ? 5'h10 : 5'(q % 17);
         spin(2304);
         @(negedge mclk);
         check("duty", drive_duty, duty_exp(pwm_high));
      end
      @(posedge mclk);
      ser_en <= 1'h1;
      for (int i = 0; i < 16; i++) begin
         q = xs();
         @(posedge mclk);
         ser_bit <= q[3];
         @(posedge mclk);
         @(negedge mclk);
         check("rx_pwm", ser_rx, q[3]);
      end
      @(posedge mclk);
      ser_en <= 1'h0;
      ser_tx_en <= 1'h1;
      for (int i = 0; i < 8; i++) begin
         q = xs();
         @(posedge mclk);
         ser_tx <= q[5];
         repeat (3) @(posedge mclk);
         @(negedge mclk);
         check("tx_oe", tach_oe, !q[5]);
         check("tx_wire", tach_in, q[5]);
      end
      @(posedge mclk);
      ser_tx_en <= 1'h0;
      wr(ADDR_MASK, 32'h3);
      wr(ADDR_STAT, 32'hf);
      spin(32);
      meas(1'h1, 2000);
      near("loss", n, 300 * TK);
      check("irq_on", irq, 1'h1);
      for (int k = 1; k <= 5; k++) begin
         meas(1'h0, 13000);
         near("off", n, off_exp(k));
         if (k < 5) begin
            meas(1'h1, 2000);
            near("on", n, 200 * TK);
         end
      end
      spin(96);
      bus(1'h0, ADDR_STATE, 32'h0);
      check("resume", {q[11:8]}, 4'h9);
      bus(1'h0, ADDR_STAT, 32'h0);
      check("stat", q[3:0], 4'hf);
      wr(ADDR_MASK, 32'h0);
      check("irq_mask", irq, 1'h0);
      wr(ADDR_MASK, 32'h2);
      check("irq_late", irq, 1'h1);
      wr(ADDR_STAT, 32'hf);
      check("irq_clr", irq, 1'h0);
      @(posedge mclk);
      rst <= 1'h1;
      strap <= 1'h0;
      ser_busy <= 1'h1;
      hall_lv <= 1'h0;
      repeat (4) @(posedge mclk);
      rst <= 1'h0;
      // No Hall edge after reset: start-up lock must stop the drive.
      meas(1'h1, 4000);
      near("start", n, LD_MS_3 * TK);
      bus(1'h0, ADDR_STATE, 32'h0);
      check("strap_lo", q[12], 1'h0);
      for (int i = 0; i < 8; i++) begin
         q = xs();
         @(posedge mclk);
         pull_low <= q[7];
         @(posedge mclk);
         @(negedge mclk);
         check("rx_wire", ser_rx, !q[7]);
         check("released", tach_oe, 1'h0);
      end
      end_of_test();
   end
endmodule
